// *** rtl/pvi_pkg.sv ***
// shared constants and types of the prioritised vectored interrupt controller
package pvi_pkg;

    // ----------------------------------------------------------------
    // vector table
    // ----------------------------------------------------------------
    localparam int NUM_VEC = 10;
    localparam int NUM_SRC = 29;
    localparam int VEC_W = 20;
    localparam int IDX_W = 4;
    localparam logic [VEC_W-1:0] VEC_BASE = 20'h00003;
    localparam logic [VEC_W-1:0] VEC_STEP = 20'h00008;
    // vectors whose upper choice is the highest level instead of high
    localparam int NUM_TOP_VEC = 2;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [1:0] RST_SYNC_INIT = 2'h0;
    localparam logic [NUM_VEC-1:0] PEND_INIT = 10'h000;
    localparam logic [3:0] SVC_INIT = 4'h0;
    localparam logic [VEC_W-1:0] VEC_INIT = 20'h00000;
    localparam logic [IDX_W-1:0] IDX_INIT = 4'h0;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        LVL_NONE,
        LVL_LOW,
        LVL_HIGH,
        LVL_TOP
    } pvi_lvl_t;

    typedef enum logic [1:0] {
        SB_RUN,
        SB_HALT,
        SB_HOLD,
        SB_XHOLD
    } pvi_sb_t;

    // level of a vector from its one-bit level choice
    function automatic pvi_lvl_t pvi_lvl_of(input int idx, input logic up);
        pvi_lvl_t upper;
        upper = (idx < NUM_TOP_VEC) ? LVL_TOP : LVL_HIGH;
        return up ? upper : LVL_LOW;
    endfunction

    // entry address of a vector
    function automatic logic [VEC_W-1:0] pvi_vec_addr(input logic [IDX_W-1:0] idx);
        logic [VEC_W-1:0] wide;
        wide = {{(VEC_W-IDX_W){1'b0}}, idx};
        return VEC_BASE + (wide << 3);
    endfunction

endpackage

// *** rtl/pvi_arbiter.sv ***
// picks the winning pending vector above the level in service
`timescale 1ns/1ps
`default_nettype none
module pvi_arbiter (
    // requests
    input wire logic [pvi_pkg::NUM_VEC-1:0] pend_i,
    input wire logic [pvi_pkg::NUM_VEC-1:0] lvl_up_i,
    input wire pvi_pkg::pvi_lvl_t cur_lvl_i,
    // winner
    output logic found_o,
    output logic [pvi_pkg::IDX_W-1:0] idx_o,
    output pvi_pkg::pvi_lvl_t lvl_o
);
    import pvi_pkg::*;

    always_comb begin
        pvi_lvl_t lv;
        lv = LVL_NONE;
        found_o = 1'b0;
        idx_o = IDX_INIT;
        lvl_o = LVL_NONE;
        // ascending scan, strict compare: ties keep the smaller address
        for (int i = 0; i < NUM_VEC; i++) begin
            lv = pvi_lvl_of(i, lvl_up_i[i]);
            if (pend_i[i] && lv > cur_lvl_i && lv > lvl_o) begin
                found_o = 1'b1;
                idx_o = IDX_W'(i);
                lvl_o = lv;
            end
        end
    end

endmodule // pvi_arbiter
`default_nettype wire

// *** rtl/pvi_ctrl.sv ***
// prioritised vectored interrupt controller with standby wake logic
// What this block does
// - three levels, highest above high above low; every request ranked by its level
// - requests at or below the level in service are not accepted
// - among different pending vectors the highest level wins
// - equal levels: smallest vector address wins
// - twenty-nine sources share ten vector addresses
// - external zero at 00003H, one at 0000BH; highest or low level
// - 00013H: ext two, four, timer zero low; 0001BH: ext three, five, base timers
// - 00023H: timer zero high, ext six; 0002BH: timer one halves, ext seven
// - 00033H: serial a, both UART receives; 0003BH: serial b, c, UART transmits
// - 00043H: converter, timers six, seven, PWM45; 0004BH: port zero, timers four, five, PWM01
// - halt stops execution, peripherals run; ends on reset or interrupt
// - hold ends on reset pin low, ext wake level, or port zero source
// - crystal hold ends as hold does, or on a base timer source
`timescale 1ns/1ps
`default_nettype none
module pvi_ctrl (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // external request lines, at programmed level
    input wire logic ext_irq_zero_i,
    input wire logic ext_irq_one_i,
    input wire logic ext_irq_two_i,
    input wire logic ext_irq_three_i,
    input wire logic ext_irq_four_i,
    input wire logic ext_irq_five_i,
    input wire logic ext_irq_six_i,
    input wire logic ext_irq_seven_i,
    // timer requests
    input wire logic timer_zero_low_irq_i,
    input wire logic timer_zero_high_irq_i,
    input wire logic timer_one_low_irq_i,
    input wire logic timer_one_high_irq_i,
    input wire logic base_timer_a_irq_i,
    input wire logic base_timer_b_irq_i,
    input wire logic timer_four_irq_i,
    input wire logic timer_five_irq_i,
    input wire logic timer_six_irq_i,
    input wire logic timer_seven_irq_i,
    // serial requests
    input wire logic sync_serial_a_i,
    input wire logic sync_serial_b_i,
    input wire logic sync_serial_c_i,
    input wire logic uart_a_rx_irq_i,
    input wire logic uart_b_rx_irq_i,
    input wire logic uart_a_tx_irq_i,
    input wire logic uart_b_tx_irq_i,
    // other requests
    input wire logic adc_irq_i,
    input wire logic pwm_pair_hi_irq_i,
    input wire logic port_zero_irq_i,
    input wire logic pwm_pair_lo_irq_i,
    // level choice per vector, 1 = upper level
    input wire logic [pvi_pkg::NUM_VEC-1:0] lvl_up_i,
    // core handshake
    input wire logic irq_ack_i,
    input wire logic irq_ret_i,
    output logic irq_req_o,
    output logic [pvi_pkg::VEC_W-1:0] irq_vec_o,
    output pvi_pkg::pvi_lvl_t irq_lvl_o,
    output pvi_pkg::pvi_lvl_t svc_lvl_o,
    // standby control
    input wire logic res_pin_n_i,
    input wire logic halt_cmd_i,
    input wire logic hold_cmd_i,
    input wire logic xhold_cmd_i,
    output logic exec_stop_o,
    output logic periph_stop_o,
    output logic base_timer_run_o
);
    import pvi_pkg::*;

    // ----------------------------------------------------------------
    // reset release
    // ----------------------------------------------------------------
    logic [1:0] rst_sync;
    logic rst_n;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_sync <= RST_SYNC_INIT;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // ----------------------------------------------------------------
    // source to vector merge
    // ----------------------------------------------------------------
    logic [NUM_VEC-1:0] vec_raw;

    assign vec_raw[0] = ext_irq_zero_i;
    assign vec_raw[1] = ext_irq_one_i;
    assign vec_raw[2] = ext_irq_two_i | timer_zero_low_irq_i | ext_irq_four_i;
    assign vec_raw[3] = ext_irq_three_i | ext_irq_five_i
                      | base_timer_a_irq_i | base_timer_b_irq_i;
    assign vec_raw[4] = timer_zero_high_irq_i | ext_irq_six_i;
    assign vec_raw[5] = timer_one_low_irq_i | timer_one_high_irq_i | ext_irq_seven_i;
    assign vec_raw[6] = sync_serial_a_i | uart_a_rx_irq_i | uart_b_rx_irq_i;
    assign vec_raw[7] = sync_serial_b_i | sync_serial_c_i
                      | uart_a_tx_irq_i | uart_b_tx_irq_i;
    assign vec_raw[8] = adc_irq_i | timer_six_irq_i | timer_seven_irq_i
                      | pwm_pair_hi_irq_i;
    assign vec_raw[9] = port_zero_irq_i | timer_four_irq_i | timer_five_irq_i
                      | pwm_pair_lo_irq_i;

    // ----------------------------------------------------------------
    // pending flags
    // ----------------------------------------------------------------
    logic [NUM_VEC-1:0] pend;
    logic [IDX_W-1:0] sel_idx;
    logic take;

    genvar gv;
    generate
        for (gv = 0; gv < NUM_VEC; gv++) begin : g_pend
            // a new request in the accept cycle keeps the flag set
            always_ff @(posedge clk_i or negedge rst_n) begin
                if (!rst_n) begin
                    pend[gv] <= PEND_INIT[gv];
                end else if (vec_raw[gv]) begin
                    pend[gv] <= 1'b1;
                end else if (take && sel_idx == IDX_W'(gv)) begin
                    pend[gv] <= 1'b0;
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // in-service levels
    // ----------------------------------------------------------------
    logic [3:0] in_svc;
    pvi_lvl_t cur_lvl;
    pvi_lvl_t sel_lvl;
    logic [3:0] next_in_svc;

    always_comb begin
        if (in_svc[LVL_TOP]) begin
            cur_lvl = LVL_TOP;
        end else if (in_svc[LVL_HIGH]) begin
            cur_lvl = LVL_HIGH;
        end else if (in_svc[LVL_LOW]) begin
            cur_lvl = LVL_LOW;
        end else begin
            cur_lvl = LVL_NONE;
        end
    end

    always_comb begin
        next_in_svc = in_svc;
        // return closes the innermost level
        if (irq_ret_i && cur_lvl != LVL_NONE) begin
            next_in_svc[cur_lvl] = 1'b0;
        end
        if (take) begin
            next_in_svc[sel_lvl] = 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            in_svc <= SVC_INIT;
        end else begin
            in_svc <= next_in_svc;
        end
    end

    assign svc_lvl_o = cur_lvl;

    // ----------------------------------------------------------------
    // selection and core handshake
    // ----------------------------------------------------------------
    logic found;
    logic [IDX_W-1:0] win_idx;
    pvi_lvl_t win_lvl;
    logic sel_valid;

    pvi_arbiter u_arb (
        .pend_i(pend),
        .lvl_up_i(lvl_up_i),
        .cur_lvl_i(cur_lvl),
        .found_o(found),
        .idx_o(win_idx),
        .lvl_o(win_lvl)
    );

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            sel_valid <= 1'b0;
            sel_idx <= IDX_INIT;
            sel_lvl <= LVL_NONE;
            irq_vec_o <= VEC_INIT;
        end else begin
            sel_valid <= found;
            sel_idx <= win_idx;
            sel_lvl <= win_lvl;
            irq_vec_o <= pvi_vec_addr(win_idx);
        end
    end

    // stale winner masked once cleared or outranked
    assign irq_req_o = sel_valid && pend[sel_idx] && (sel_lvl > cur_lvl);
    assign irq_lvl_o = sel_lvl;
    assign take = irq_ack_i && irq_req_o;

    // ----------------------------------------------------------------
    // standby modes
    // ----------------------------------------------------------------
    pvi_sb_t sb_state;
    pvi_sb_t next_sb_state;
    logic hold_wake;
    logic xhold_wake;

    assign hold_wake = !res_pin_n_i || ext_irq_zero_i || ext_irq_one_i || ext_irq_two_i
                     || ext_irq_four_i || ext_irq_five_i || port_zero_irq_i;
    assign xhold_wake = hold_wake || base_timer_a_irq_i || base_timer_b_irq_i;

    always_comb begin
        next_sb_state = sb_state;
        unique case (sb_state)
            SB_RUN: begin
                if (halt_cmd_i) begin
                    next_sb_state = SB_HALT;
                end else if (hold_cmd_i) begin
                    next_sb_state = SB_HOLD;
                end else if (xhold_cmd_i) begin
                    next_sb_state = SB_XHOLD;
                end
            end
            SB_HALT: begin
                if (|pend || |vec_raw) begin
                    next_sb_state = SB_RUN;
                end
            end
            SB_HOLD: begin
                if (hold_wake) begin
                    next_sb_state = SB_RUN;
                end
            end
            SB_XHOLD: begin
                if (xhold_wake) begin
                    next_sb_state = SB_RUN;
                end
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            sb_state <= SB_RUN;
        end else begin
            sb_state <= next_sb_state;
        end
    end

    assign exec_stop_o = (sb_state != SB_RUN);
    assign periph_stop_o = (sb_state == SB_HOLD) || (sb_state == SB_XHOLD);
    assign base_timer_run_o = (sb_state != SB_HOLD);

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    logic better_exists;

    always_comb begin
        better_exists = 1'b0;
        for (int i = 0; i < NUM_VEC; i++) begin
            if (pend[i] && IDX_W'(i) != sel_idx
                && (pvi_lvl_of(i, lvl_up_i[i]) > sel_lvl
                    || (pvi_lvl_of(i, lvl_up_i[i]) == sel_lvl && IDX_W'(i) < sel_idx))) begin
                better_exists = 1'b1;
            end
        end
    end

    a_req_above_svc: assert property (@(posedge clk_i) disable iff (!rst_n)
        irq_req_o |-> irq_lvl_o > cur_lvl)
        else $error("request offered at or below level in service");

    a_winner_best: assert property (@(posedge clk_i) disable iff (!rst_n)
        (irq_req_o && $stable(pend) && $stable(lvl_up_i) && $stable(cur_lvl))
            |-> !better_exists)
        else $error("offered vector is not the best pending one");

    a_pend_holds: assert property (@(posedge clk_i) disable iff (!rst_n)
        (pend[3] && !(take && sel_idx == 4'h3)) |=> pend[3])
        else $error("pending flag lost without acceptance");

    a_ack_sets_svc: assert property (@(posedge clk_i) disable iff (!rst_n)
        (take && !irq_ret_i)
            |=> (cur_lvl == $past(sel_lvl)) && !(irq_req_o && sel_idx == $past(sel_idx)))
        else $error("accepted level not in service");

    a_vec_address: assert property (@(posedge clk_i) disable iff (!rst_n)
        irq_req_o |-> irq_vec_o == VEC_BASE + VEC_STEP * {16'h0000, sel_idx})
        else $error("vector address mismatch");

    a_src_to_vec: assert property (@(posedge clk_i) disable iff (!rst_n)
        ext_irq_six_i |=> pend[4])
        else $error("source did not pend its vector");

    a_top_level_vecs: assert property (@(posedge clk_i) disable iff (!rst_n)
        (irq_req_o && irq_lvl_o == LVL_TOP) |-> sel_idx < 4'h2)
        else $error("highest level on a vector that cannot hold it");

    a_halt_wake: assert property (@(posedge clk_i) disable iff (!rst_n)
        (sb_state == SB_HALT && |vec_raw) |=> sb_state == SB_RUN && !exec_stop_o)
        else $error("halt not ended by interrupt");

    a_hold_wake: assert property (@(posedge clk_i) disable iff (!rst_n)
        (sb_state == SB_HOLD && port_zero_irq_i) |=> sb_state == SB_RUN)
        else $error("hold not ended by port zero source");

    a_xhold_timer: assert property (@(posedge clk_i) disable iff (!rst_n)
        (sb_state == SB_XHOLD && base_timer_b_irq_i) |=> sb_state == SB_RUN)
        else $error("crystal hold not ended by base timer");

    a_hold_sleeps: assert property (@(posedge clk_i) disable iff (!rst_n)
        (sb_state == SB_HOLD && !hold_wake && !base_timer_a_irq_i)
            |=> sb_state == SB_HOLD && periph_stop_o)
        else $error("hold left without a wake event");

endmodule // pvi_ctrl
`default_nettype wire

// *** bench/pvi_core_model.sv ***
// core-side partner: takes offered vectors and returns from handlers on request
`timescale 1ns/1ps
`default_nettype none
module pvi_core_model (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // controller side
    input wire logic irq_req_i,
    input wire logic [pvi_pkg::VEC_W-1:0] irq_vec_i,
    input wire pvi_pkg::pvi_lvl_t irq_lvl_i,
    output logic irq_ack_o,
    output logic irq_ret_o,
    // bench side
    input wire logic take_en_i,
    input wire logic ret_go_i,
    output logic [pvi_pkg::VEC_W-1:0] got_vec_o,
    output pvi_pkg::pvi_lvl_t got_lvl_o,
    output logic [7:0] got_cnt_o
);
    import pvi_pkg::*;
    // ack only against a standing request, one cycle, never twice in a row
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_ack_o <= 1'b0;
            irq_ret_o <= 1'b0;
            got_vec_o <= VEC_INIT;
            got_lvl_o <= LVL_NONE;
            got_cnt_o <= 8'h00;
        end else begin
            irq_ack_o <= take_en_i && irq_req_i && !irq_ack_o;
            irq_ret_o <= ret_go_i;
            if (irq_ack_o && irq_req_i) begin
                got_vec_o <= irq_vec_i;
                got_lvl_o <= irq_lvl_i;
                got_cnt_o <= got_cnt_o + 8'h01;
            end
        end
    end
endmodule // pvi_core_model
`default_nettype wire

// *** bench/test_priority_vector_interrupt_ctrl.sv ***
// self-checking bench of the interrupt controller
`timescale 1ns/1ps
`default_nettype none
module test_priority_vector_interrupt_ctrl;
    import pvi_pkg::*;
    // ----------------------------------------------------------------
    // signals
    // ----------------------------------------------------------------
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [28:0] src = '0;
    logic [NUM_VEC-1:0] lu = '0;
    logic res_pin_n = 1'b1, halt_cmd = 1'b0, hold_cmd = 1'b0, xhold_cmd = 1'b0;
    logic take_en = 1'b1, ret_go = 1'b0, ack, ret, req, stop, pstop, btrun;
    logic [VEC_W-1:0] vec, got_vec;
    pvi_lvl_t lvl, svc, got_lvl;
    logic [7:0] got_cnt, seen = 8'h00;
    int err_count = 0;
    int tests_run = 0;
    int src_vec [29] = '{0,1,2,3,2,3,4,5,2,4,5,5,3,3,9,9,8,8,6,7,7,6,6,7,7,8,8,9,9};
    int wake_bit [10] = '{0,0,1,2,4,5,27,12,13,25};
    always #5 clk_i = ~clk_i;
    pvi_ctrl DUT (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .ext_irq_zero_i(src[0]), .ext_irq_one_i(src[1]), .ext_irq_two_i(src[2]),
        .ext_irq_three_i(src[3]), .ext_irq_four_i(src[4]), .ext_irq_five_i(src[5]),
        .ext_irq_six_i(src[6]), .ext_irq_seven_i(src[7]), .timer_zero_low_irq_i(src[8]),
        .timer_zero_high_irq_i(src[9]), .timer_one_low_irq_i(src[10]),
        .timer_one_high_irq_i(src[11]), .base_timer_a_irq_i(src[12]),
        .base_timer_b_irq_i(src[13]), .timer_four_irq_i(src[14]), .timer_five_irq_i(src[15]),
        .timer_six_irq_i(src[16]), .timer_seven_irq_i(src[17]), .sync_serial_a_i(src[18]),
        .sync_serial_b_i(src[19]), .sync_serial_c_i(src[20]), .uart_a_rx_irq_i(src[21]),
        .uart_b_rx_irq_i(src[22]), .uart_a_tx_irq_i(src[23]), .uart_b_tx_irq_i(src[24]),
        .adc_irq_i(src[25]), .pwm_pair_hi_irq_i(src[26]), .port_zero_irq_i(src[27]),
        .pwm_pair_lo_irq_i(src[28]), .lvl_up_i(lu), .irq_ack_i(ack), .irq_ret_i(ret),
        .irq_req_o(req), .irq_vec_o(vec), .irq_lvl_o(lvl), .svc_lvl_o(svc),
        .res_pin_n_i(res_pin_n), .halt_cmd_i(halt_cmd), .hold_cmd_i(hold_cmd),
        .xhold_cmd_i(xhold_cmd), .exec_stop_o(stop), .periph_stop_o(pstop),
        .base_timer_run_o(btrun));
    pvi_core_model core (.clk_i(clk_i), .rst_n_i(rst_n_i), .irq_req_i(req), .irq_vec_i(vec),
        .irq_lvl_i(lvl), .irq_ack_o(ack), .irq_ret_o(ret), .take_en_i(take_en),
        .ret_go_i(ret_go), .got_vec_o(got_vec), .got_lvl_o(got_lvl), .got_cnt_o(got_cnt));
    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic print_verdict();
        $display("comparisons %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] s, input logic [31:0] e, input string what);
        tests_run++;
        if (s !== e) begin
            err_count++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, s, e);
        end
    endtask
    task automatic pulse(input logic [28:0] s);
        @(posedge clk_i) src <= s;
        @(posedge clk_i) src <= '0;
    endtask
    task automatic take(input int idx, input pvi_lvl_t l);
        int n;
        n = 0;
        while (got_cnt === seen && n < 40) begin
            @(negedge clk_i);
            n++;
        end
        if (got_cnt === seen) begin
            err_count++;
            print_verdict();
        end
        seen = got_cnt;
        check(32'(got_vec), 32'h3 + 32'(idx) * 8, "vector address");
        check(32'(got_lvl), 32'(l), "offered level");
        check(32'(svc), 32'(l), "level in service");
    endtask
    task automatic ret_to(input pvi_lvl_t l, input bit chk);
        @(posedge clk_i) ret_go <= 1'b1;
        @(posedge clk_i) ret_go <= 1'b0;
        @(posedge clk_i);
        @(negedge clk_i);
        if (chk) check(32'(svc), 32'(l), "level after return");
    endtask
    task automatic quiet(input int n);
        repeat (n) begin
            @(negedge clk_i);
            check(32'(req), 32'h0, "request held back");
        end
    endtask
    task automatic drain();
        @(posedge clk_i) take_en <= 1'b1;
        repeat (30) begin
            @(negedge clk_i);
            if (got_cnt !== seen) begin
                seen = got_cnt;
                ret_to(LVL_NONE, 1'b0);
            end
        end
        check(32'(req), 32'h0, "nothing left pending");
    endtask
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        @(negedge clk_i);
        check(32'({req, svc, stop, pstop, btrun}), 32'h01, "reset outputs");
        $display("reset test done");
    endtask
    task automatic t_map();
        for (int p = 0; p < 2; p++) begin
            for (int i = 0; i < NUM_SRC; i++) begin
                @(posedge clk_i) lu <= {NUM_VEC{p[0]}};
                pulse(29'(1) << i);
                take(src_vec[i], p == 0 ? LVL_LOW : src_vec[i] < 2 ? LVL_TOP : LVL_HIGH);
                ret_to(LVL_NONE, 1'b1);
            end
        end
        $display("vector map test done");
    endtask
    task automatic t_rank();
        @(posedge clk_i) take_en <= 1'b0;
        lu <= 10'h023;
        pulse(29'h08000407);
        repeat (4) @(posedge clk_i);
        take_en <= 1'b1;
        take(0, LVL_TOP);
        quiet(6);
        ret_to(LVL_NONE, 1'b1);
        take(1, LVL_TOP);
        ret_to(LVL_NONE, 1'b1);
        take(5, LVL_HIGH);
        quiet(4);
        ret_to(LVL_NONE, 1'b1);
        take(2, LVL_LOW);
        quiet(4);
        ret_to(LVL_NONE, 1'b1);
        take(9, LVL_LOW);
        ret_to(LVL_NONE, 1'b1);
        $display("ranking test done");
    endtask
    task automatic t_nest();
        @(posedge clk_i) lu <= 10'h001;
        pulse(29'h08000000);
        take(9, LVL_LOW);
        pulse(29'h00000001);
        take(0, LVL_TOP);
        ret_to(LVL_LOW, 1'b1);
        ret_to(LVL_NONE, 1'b1);
        $display("nesting test done");
    endtask
    task automatic t_halt();
        @(posedge clk_i) lu <= '0;
        halt_cmd <= 1'b1;
        @(posedge clk_i) halt_cmd <= 1'b0;
        repeat (4) begin
            @(negedge clk_i);
            check(32'({stop, pstop, btrun}), 32'h5, "halt outputs");
        end
        pulse(29'h02000000);
        @(negedge clk_i);
        check(32'(stop), 32'h0, "halt ended by request");
        take(8, LVL_LOW);
        ret_to(LVL_NONE, 1'b1);
        $display("halt test done");
    endtask
    task automatic t_hold();
        bit woke;
        for (int m = 0; m < 2; m++) begin
            for (int k = 0; k < 10; k++) begin
                @(posedge clk_i) take_en <= 1'b0;
                hold_cmd <= (m == 0);
                xhold_cmd <= (m == 1);
                @(posedge clk_i) hold_cmd <= 1'b0;
                xhold_cmd <= 1'b0;
                @(negedge clk_i);
                check(32'({stop, pstop, btrun}), 32'({2'b11, m[0]}), "hold outputs");
                @(posedge clk_i);
                if (k == 0) res_pin_n <= 1'b0;
                else src <= 29'(1) << wake_bit[k];
                @(posedge clk_i) res_pin_n <= 1'b1;
                src <= '0;
                @(negedge clk_i);
                woke = (k < 7) || (k < 9 && m == 1);
                check(32'(stop), 32'(!woke), "hold wake");
                if (!woke) begin
                    @(posedge clk_i) res_pin_n <= 1'b0;
                    @(posedge clk_i) res_pin_n <= 1'b1;
                end
                drain();
            end
        end
        $display("hold test done");
    endtask
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        #500000;
        err_count++;
        print_verdict();
    end
    initial begin
        t_reset();
        repeat (3) @(posedge clk_i);
        rst_n_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        t_map();
        t_rank();
        t_nest();
        t_halt();
        t_hold();
        print_verdict();
    end
endmodule // test_priority_vector_interrupt_ctrl
`default_nettype wire
